// *** rss_alu.sv ***
// Combinational rotate and subtract unit
`timescale 1ns/1ps
`default_nettype none
module rss_alu (
   rss_alu_if.alu a
);
   logic [7:0] minuend;
   logic [7:0] subtrahend;
   logic       borrow;
   logic [8:0] diff;
   logic [4:0] ndiff;
   logic [7:0] rotl;
   logic [7:0] rotr;

   // Literal minus accumulator, else file minus accumulator
   assign minuend    = (a.op == rss_pkg::OP_SUBL) ? a.literal : a.file_val; // RQ4 RQ6
   assign subtrahend = a.acc_val;
   // Carry low means a borrow is owed
   assign borrow     = (a.op == rss_pkg::OP_SUBB) ? ~a.carry_in : 1'b0; // RQ7
   // Ninth bit set means the subtrahend plus borrow was larger
   assign diff  = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow}; // RQ5
   assign ndiff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow}; // RQ5
   // Rotations pass through the carry
   assign rotl = {a.file_val[6:0], a.carry_in}; // RQ1
   assign rotr = {a.carry_in, a.file_val[7:1]}; // RQ3

   assign a.is_sub = (a.op == rss_pkg::OP_SUBL) || (a.op == rss_pkg::OP_SUBF)
                     || (a.op == rss_pkg::OP_SUBB);
   // Result and flag selection
   assign a.result    = (a.op == rss_pkg::OP_ROTL) ? rotl :
                        (a.op == rss_pkg::OP_ROTR) ? rotr : diff[7:0];
   assign a.carry_out = (a.op == rss_pkg::OP_ROTL) ? a.file_val[7] : // RQ1
                        (a.op == rss_pkg::OP_ROTR) ? a.file_val[0] : ~diff[8]; // RQ3 RQ5
   assign a.nc_out    = ~ndiff[4]; // RQ5
   assign a.z_out     = (diff[7:0] == 8'h00); // RQ11
endmodule
`default_nettype wire

// *** rss_alu_if.sv ***
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface rss_alu_if;
   logic [2:0] op;
   logic [7:0] file_val;
   logic [7:0] acc_val;
   logic [7:0] literal;
   logic       carry_in;
   logic [7:0] result;
   logic       carry_out;
   logic       nc_out;
   logic       z_out;
   logic       is_sub;

   modport core (output op, file_val, acc_val, literal, carry_in,
                 input  result, carry_out, nc_out, z_out, is_sub);
   modport alu  (input  op, file_val, acc_val, literal, carry_in,
                 output result, carry_out, nc_out, z_out, is_sub);
endinterface
`default_nettype wire

// *** rss_datapath.sv ***
// Top of the rotate, subtract and sleep execution datapath
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1: Rotate left: file bit 7 to carry, old carry to bit 0; only carry changes.
// RQ2: Destination bit 0 writes accumulator, 1 writes back the addressed file register.
// RQ3: Rotate right: file bit 0 to carry, old carry to bit 7; only carry changes.
// RQ4: Literal minus accumulator, result always into the accumulator.
// RQ5: Subtracts set carry, nibble carry, zero; carry set when no borrow occurs.
// RQ6: File minus accumulator, routed by the destination bit.
// RQ7: File minus accumulator minus inverted carry, flags updated, routed by destination.
// RQ8: Sleep clears power-down flag and sets time-out flag, nothing else.
// RQ9: Sleep clears watchdog counter and prescaler.
// RQ10: After sleep, execution halts until a wake event.
// RQ11: One cycle per instruction; zero flag set exactly for a zero result.
module rss_datapath (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       op_valid,
   input  wire logic [2:0] op_code,
   input  wire logic [6:0] op_file,
   input  wire logic       op_dest,
   input  wire logic [7:0] op_literal,
   input  wire logic       wake_pin,
   input  wire logic [7:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   output logic [7:0]      bus_rdata_q,
   output logic [7:0]      acc_q,
   output logic [7:0]      status_q,
   output logic            op_done_q,
   output logic            sleeping_q,
   output logic            dog_timeout_q
);
   typedef enum logic [1:0] {
      RSS_RUN   = 2'b01,
      RSS_SLEEP = 2'b10
   } rss_state_t;

   rss_state_t state_q;
   rss_state_t state_d;

   logic [7:0] file_mem [rss_pkg::FILE_DEPTH];
   logic [7:0] ctrl_q;
   logic       wake_s1_q;
   logic       wake_s2_q;
   logic [7:0] dog_cnt;
   logic [7:0] dog_pre;
   logic       dog_fire;

   rss_alu_if alu_bus ();

   // Decoded issue conditions
   logic       running;
   logic       exec;
   logic       exec_alu;
   logic       exec_sleep;
   logic       to_acc;
   logic       to_file;
   logic [7:0] file_rd;

   assign running    = (state_q == RSS_RUN);
   assign exec       = op_valid && running; // RQ10
   assign exec_alu   = exec && (op_code <= rss_pkg::OP_SUBB);
   assign exec_sleep = exec && (op_code == rss_pkg::OP_SLEEP);
   // Literal subtract ignores the destination bit
   assign to_acc     = exec_alu && ((op_code == rss_pkg::OP_SUBL) || !op_dest); // RQ2 RQ4
   assign to_file    = exec_alu && (op_code != rss_pkg::OP_SUBL) && op_dest; // RQ2
   assign file_rd    = file_mem[op_file];

   // Operands into the arithmetic unit
   assign alu_bus.op       = op_code;
   assign alu_bus.file_val = file_rd;
   assign alu_bus.acc_val  = acc_q;
   assign alu_bus.literal  = op_literal;
   assign alu_bus.carry_in = status_q[rss_pkg::ST_C];

   rss_alu u_alu (
      .a (alu_bus.alu)
   );

   // The dog keeps counting in sleep, so its wrap can end a sleep
   rss_wdog u_wdog (
      .clk       (clk),
      .rst       (rst),
      .enable    (ctrl_q[rss_pkg::CT_DOG_EN]),
      .clear     (exec_sleep), // RQ9
      .count_q   (dog_cnt),
      .pre_q     (dog_pre),
      .timeout_q (dog_fire)
   );

   // Register port decode
   logic       hit_file;
   logic       hit_acc;
   logic       hit_status;
   logic       hit_ctrl;
   logic       hit_dog_cnt;
   logic       hit_dog_pre;
   logic       wr_acc;
   logic       wr_status;
   logic       wr_ctrl;
   logic       wr_file;
   logic [7:0] rd_mux;

   // One named hit per mapped address
   assign hit_file    = !bus_addr[7];
   assign hit_acc     = (bus_addr == rss_pkg::ADDR_ACC);
   assign hit_status  = (bus_addr == rss_pkg::ADDR_STATUS);
   assign hit_ctrl    = (bus_addr == rss_pkg::ADDR_CTRL);
   assign hit_dog_cnt = (bus_addr == rss_pkg::ADDR_DOG_CNT);
   assign hit_dog_pre = (bus_addr == rss_pkg::ADDR_DOG_PRE);

   // Write strobes; the dog views are read only
   assign wr_acc    = bus_wr && hit_acc;
   assign wr_status = bus_wr && hit_status;
   assign wr_ctrl   = bus_wr && hit_ctrl;
   // Single write port: an executing write-back takes it over
   assign wr_file   = bus_wr && hit_file && !to_file;

   // Read mux; unmapped addresses read zero
   assign rd_mux = hit_file    ? file_mem[bus_addr[6:0]] :
                   hit_acc     ? acc_q :
                   hit_status  ? status_q :
                   hit_ctrl    ? ctrl_q :
                   hit_dog_cnt ? dog_cnt :
                   hit_dog_pre ? dog_pre : 8'h00;

   // Accumulator next value; execution wins over a software write
   logic [7:0] acc_d;
   assign acc_d = to_acc ? alu_bus.result : // RQ2 RQ4 RQ6 RQ7
                  wr_acc ? bus_wdata : acc_q;

   // Status next value, hardware updates applied after software
   logic [7:0] status_d;
   always_comb
   begin
      status_d = status_q;
      if (wr_status)
      begin
         status_d = (status_q & ~rss_pkg::STATUS_SW) | (bus_wdata & rss_pkg::STATUS_SW);
      end
      if (exec_alu)
      begin
         status_d[rss_pkg::ST_C] = alu_bus.carry_out; // RQ1 RQ3 RQ5
         if (alu_bus.is_sub)
         begin
            status_d[rss_pkg::ST_NC] = alu_bus.nc_out; // RQ5
            status_d[rss_pkg::ST_Z]  = alu_bus.z_out; // RQ11
         end
      end
      // Timeout marks the flag; a sleep in the same cycle restarts the dog
      if (dog_fire)
      begin
         status_d[rss_pkg::ST_TO] = 1'b0;
      end
      if (exec_sleep)
      begin
         status_d[rss_pkg::ST_PWRDN] = 1'b0; // RQ8
         status_d[rss_pkg::ST_TO] = 1'b1; // RQ8
      end
      status_d = status_d & (rss_pkg::STATUS_SW | rss_pkg::STATUS_RST);
   end

   // Run and sleep sequencing
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         RSS_RUN:
         begin
            if (exec_sleep)
            begin
               state_d = RSS_SLEEP; // RQ10
            end
         end
         RSS_SLEEP:
         begin
            if (wake_s2_q || dog_fire)
            begin
               state_d = RSS_RUN;
            end
         end
         default:
         begin
            state_d = RSS_RUN;
         end
      endcase
   end

   // Wake pin synchroniser; only the second stage is used
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end
      else
      begin
         wake_s1_q <= wake_pin;
         wake_s2_q <= wake_s1_q;
      end
   end

   // Control next value; reserved bits are masked so they always read zero
   // Only the dog enable is kept, so software cannot park junk there
   logic [7:0] ctrl_d;
   assign ctrl_d = wr_ctrl ? (bus_wdata & rss_pkg::CTRL_SW) : ctrl_q;

   // Run or sleep state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= RSS_RUN;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Accumulator
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc_q <= 8'h00;
      end
      else
      begin
         acc_q <= acc_d;
      end
   end

   // Status flags; power-down and time-out come up set
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         status_q <= rss_pkg::STATUS_RST;
      end
      else
      begin
         status_q <= status_d;
      end
   end

   // Control register; the dog is off after reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_q <= rss_pkg::CTRL_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
      end
   end

   // Read data stands for one cycle only, zero otherwise
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bus_rdata_q <= 8'h00;
      end
      else
      begin
         bus_rdata_q <= bus_rd ? rd_mux : 8'h00;
      end
   end

   // Pulses and sleep level, all single flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         op_done_q     <= 1'b0;
         sleeping_q    <= 1'b0;
         dog_timeout_q <= 1'b0;
      end
      else
      begin
         op_done_q     <= exec_alu || exec_sleep; // RQ11
         // Follows the next state so the level moves with the state itself
         sleeping_q    <= (state_d == RSS_SLEEP); // RQ10
         dog_timeout_q <= dog_fire;
      end
   end

   // File registers; no reset, contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (to_file)
      begin
         file_mem[op_file] <= alu_bus.result; // RQ2 RQ6 RQ7
      end
      else if (wr_file)
      begin
         file_mem[bus_addr[6:0]] <= bus_wdata;
      end
   end
endmodule
`default_nettype wire

// *** rss_datapath_checker.sv ***
// Concurrent checks on the datapath top ports
`timescale 1ns/1ps
`default_nettype none
module rss_datapath_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       op_valid,
   input wire logic [2:0] op_code,
   input wire logic       op_dest,
   input wire logic [7:0] op_literal,
   input wire logic       bus_wr,
   input wire logic [7:0] acc_q,
   input wire logic [7:0] status_q,
   input wire logic       op_done_q,
   input wire logic       sleeping_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Issue is only taken while running
   wire go   = op_valid && !sleeping_q;
   wire subl = go && op_code == rss_pkg::OP_SUBL;
   done_pulse_a: assert property (go && op_code <= rss_pkg::OP_SLEEP |=> op_done_q)
      else $error("done missing");
   bad_code_a: assert property (op_valid && op_code > rss_pkg::OP_SLEEP |=> !op_done_q)
      else $error("done on bad code");
   asleep_op_a: assert property (sleeping_q && op_valid |=> !op_done_q)
      else $error("op ran while asleep");
   sleep_flags_a: assert property (go && op_code == rss_pkg::OP_SLEEP |=>
      !status_q[3] && status_q[4] && sleeping_q) else $error("sleep flags wrong");
   // Bus status write excluded, it could move these bits
   rot_flags_a: assert property (go && op_code <= rss_pkg::OP_ROTR && !bus_wr |=>
      status_q[2:1] == $past(status_q[2:1])) else $error("rotate touched flags");
   subl_res_a: assert property (subl |=> acc_q == $past(op_literal) - $past(acc_q))
      else $error("literal minus acc wrong");
   subl_c_a: assert property (subl |=> status_q[0] == ($past(acc_q) <= $past(op_literal)))
      else $error("carry wrong");
   subl_nc_a: assert property (subl |=>
      status_q[1] == ($past(acc_q[3:0]) <= $past(op_literal[3:0])))
      else $error("nibble carry wrong");
   zero_flag_a: assert property (subl |=> status_q[2] == (acc_q == 8'h00))
      else $error("zero flag wrong");
   dest_file_a: assert property (go && op_code == rss_pkg::OP_SUBF && op_dest && !bus_wr |=>
      acc_q == $past(acc_q)) else $error("acc changed for file dest");
   cover property (subl);
   cover property (go && op_code == rss_pkg::OP_SUBB);
   cover property (go && op_code == rss_pkg::OP_SLEEP);
endmodule
bind rss_datapath rss_datapath_checker u_chk (.clk, .rst, .op_valid, .op_code, .op_dest,
   .op_literal, .bus_wr, .acc_q, .status_q, .op_done_q, .sleeping_q);
`default_nettype wire

// *** rss_pkg.sv ***
// Shared constants for the rotate, subtract and sleep datapath
package rss_pkg;
   localparam int DATA_W      = 8;
   localparam int FILE_AW     = 7;
   localparam int FILE_DEPTH  = 128;
   localparam int BUS_AW      = 8;
   localparam int DOG_W       = 8;

   // Instruction codes on the issue port
   localparam logic [2:0] OP_ROTL  = 3'h0;
   localparam logic [2:0] OP_ROTR  = 3'h1;
   localparam logic [2:0] OP_SUBL  = 3'h2;
   localparam logic [2:0] OP_SUBF  = 3'h3;
   localparam logic [2:0] OP_SUBB  = 3'h4;
   localparam logic [2:0] OP_SLEEP = 3'h5;

   // Register port map; addresses below ADDR_ACC hit the file registers
   localparam logic [7:0] ADDR_ACC     = 8'h80;
   localparam logic [7:0] ADDR_STATUS  = 8'h81;
   localparam logic [7:0] ADDR_CTRL    = 8'h82;
   localparam logic [7:0] ADDR_DOG_CNT = 8'h83;
   localparam logic [7:0] ADDR_DOG_PRE = 8'h84;

   // Status bit positions
   localparam int ST_C     = 0;
   localparam int ST_NC    = 1;
   localparam int ST_Z     = 2;
   localparam int ST_PWRDN = 3;
   localparam int ST_TO    = 4;
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] STATUS_SW  = 8'h07;

   // Control bit positions
   localparam int CT_DOG_EN = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_SW  = 8'h01;

   // Watchdog terminal values
   localparam logic [7:0] DOG_ZERO = 8'h00;
   localparam logic [7:0] DOG_MAX  = 8'hFF;
endpackage

// *** rss_wdog.sv ***
// Watchdog prescaler and counter with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module rss_wdog (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       clear,
   output logic [7:0]      count_q,
   output logic [7:0]      pre_q,
   output logic            timeout_q
);
   logic       pre_wrap;
   logic       cnt_wrap;
   logic [7:0] pre_d;
   logic [7:0] count_d;

   // Counter steps once per prescaler wrap
   assign pre_wrap = enable && (pre_q == rss_pkg::DOG_MAX);
   assign cnt_wrap = pre_wrap && (count_q == rss_pkg::DOG_MAX);
   assign pre_d    = clear ? rss_pkg::DOG_ZERO : // RQ9
                     enable ? pre_q + 8'h01 : pre_q;
   assign count_d  = clear ? rss_pkg::DOG_ZERO : // RQ9
                     pre_wrap ? count_q + 8'h01 : count_q;

   // Clear beats a wrap in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pre_q     <= rss_pkg::DOG_ZERO;
         count_q   <= rss_pkg::DOG_ZERO;
         timeout_q <= 1'b0;
      end
      else
      begin
         pre_q     <= pre_d;
         count_q   <= count_d;
         timeout_q <= cnt_wrap && !clear;
      end
   end
endmodule
`default_nettype wire

// *** tb_rss_datapath.sv ***
// Directed testbench for the rotate, subtract and sleep datapath
`timescale 1ns/1ps
`default_nettype none
module tb_rss_datapath;
   logic       clk, rst, op_valid, op_dest, wake_pin, bus_wr, bus_rd;
   logic       op_done_q, sleeping_q, dog_timeout_q;
   logic [2:0] op_code;
   logic [6:0] op_file;
   logic [7:0] op_literal, bus_addr, bus_wdata, bus_rdata_q, acc_q, status_q;
   int         errors, samples_checked;
   rss_datapath DUT (.clk, .rst, .op_valid, .op_code, .op_file, .op_dest, .op_literal,
      .wake_pin, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_q, .acc_q,
      .status_q, .op_done_q, .sleeping_q, .dog_timeout_q);
   // Free running core clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      samples_checked++;
      if (s !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 chk("rdata", bus_rdata_q, e);
   endtask
   // All ops use file register 3
   task automatic op(logic [2:0] c, logic d, logic [7:0] l, logic e);
      @(posedge clk);
      op_valid   <= 1'b1;
      op_code    <= c;
      op_file    <= 7'h03;
      op_dest    <= d;
      op_literal <= l;
      @(posedge clk);
      op_valid <= 1'b0;
      #1 chk("done", op_done_q, e);
   endtask
   task automatic t_reset;
      chk("acc", acc_q, 8'h00);
      chk("status", status_q, 8'h18);
      chk("sleep", sleeping_q, 8'h00);
      wr(rss_pkg::ADDR_STATUS, 8'hFF);
      rd(rss_pkg::ADDR_STATUS, 8'h1F);
      rd(8'h90, 8'h00);
   endtask
   // Preload nibble carry and zero high so a rotate that touches them shows
   task automatic t_case(logic [2:0] c, logic d, logic [7:0] f, a, logic ci,
                         logic [7:0] l, r, st);
      logic wf;
      wf = d && c != rss_pkg::OP_SUBL;
      wr(8'h03, f);
      wr(rss_pkg::ADDR_ACC, a);
      wr(rss_pkg::ADDR_STATUS, {5'h0, 2'b11, ci});
      op(c, d, l, 1'b1);
      chk("acc", acc_q, wf ? a : r);
      chk("status", status_q, st);
      rd(8'h03, wf ? r : f);
   endtask
   task automatic t_ops;
      t_case(rss_pkg::OP_ROTL, 1'b0, 8'hE6, 8'h00, 1'b0, 8'h00, 8'hCC, 8'h1F);
      t_case(rss_pkg::OP_ROTR, 1'b1, 8'hE6, 8'h00, 1'b1, 8'h00, 8'hF3, 8'h1E);
      t_case(rss_pkg::OP_SUBL, 1'b0, 8'h00, 8'h08, 1'b0, 8'h05, 8'hFD, 8'h18);
      t_case(rss_pkg::OP_SUBL, 1'b1, 8'h00, 8'h10, 1'b0, 8'h10, 8'h00, 8'h1F);
      t_case(rss_pkg::OP_SUBF, 1'b0, 8'h2A, 8'h0B, 1'b0, 8'h00, 8'h1F, 8'h19);
      t_case(rss_pkg::OP_SUBF, 1'b1, 8'h30, 8'h31, 1'b0, 8'h00, 8'hFF, 8'h18);
      t_case(rss_pkg::OP_SUBB, 1'b0, 8'h20, 8'h10, 1'b0, 8'h00, 8'h0F, 8'h19);
      t_case(rss_pkg::OP_SUBB, 1'b1, 8'h44, 8'h44, 1'b1, 8'h00, 8'h00, 8'h1F);
      op(3'h6, 1'b0, 8'h00, 1'b0);
      chk("acc", acc_q, 8'h44);
   endtask
   // Dog runs long enough to count before sleep clears it
   task automatic t_sleep;
      wr(rss_pkg::ADDR_CTRL, 8'h01);
      wr(rss_pkg::ADDR_STATUS, 8'h00);
      repeat (600) @(posedge clk);
      op(rss_pkg::OP_SLEEP, 1'b0, 8'h00, 1'b1);
      chk("status", status_q, 8'h10);
      chk("sleep", sleeping_q, 8'h01);
      rd(rss_pkg::ADDR_DOG_CNT, 8'h00);
      // Prescaler restarted at the sleep edge, three steps before this read
      rd(rss_pkg::ADDR_DOG_PRE, 8'h03);
      op(rss_pkg::OP_SUBL, 1'b0, 8'h55, 1'b0);
      chk("acc", acc_q, 8'h44);
      @(posedge clk);
      wake_pin <= 1'b1;
      repeat (10)
      begin
         if (sleeping_q === 1'b1)
         begin
            @(posedge clk);
            #1;
         end
      end
      chk("sleep", sleeping_q, 8'h00);
      @(posedge clk);
      wake_pin <= 1'b0;
      repeat (70000)
      begin
         if (dog_timeout_q !== 1'b1)
         begin
            @(posedge clk);
            #1;
         end
      end
      chk("timeout", dog_timeout_q, 8'h01);
      // A wrap while running only drops the time-out flag
      chk("status", status_q, 8'h00);
   endtask
   task automatic give_verdict;
      if (errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      {rst, op_valid, op_dest, wake_pin, bus_wr, bus_rd} = 6'h3F & 6'h20;
      {op_code, op_file, op_literal, bus_addr, bus_wdata} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 t_reset;
      t_ops;
      t_sleep;
      give_verdict;
   end
   // Hang guard, well past the watchdog wrap
   initial
   begin
      #2000000;
      errors++;
      give_verdict;
   end
endmodule
`default_nettype wire
